// [cba_pkg.sv]
// Shared constants and types for the CAN boot bit-rate detector.
package cba_pkg;
    localparam int MEASURE_W = 16;
    localparam logic [3:0] STUFF_TARGET = 4'h5;
    localparam int FRAME_BITS = 29;
    localparam logic [15:0] PRESCALE_SPAN = 16'h05ab;
    localparam logic [11:0] TQ_UNIT = 12'h03a;
    localparam logic [5:0] TQ_MIN = 6'h08;
    localparam logic [5:0] TQ_MAX = 6'h19;
    localparam logic [1:0] SJW_FIELD = 2'h1;
    localparam logic [10:0] ACK_ID = 11'h0e6;
    localparam logic [3:0] ACK_LEN = 4'h3;
    localparam logic [10:0] RECV_ID = 11'h005;
    localparam logic [10:0] RECV_MASK = 11'h7ff;
    localparam logic [7:0] CAN_LOAD_BYTES = 8'h80;
    localparam logic [7:0] SERIAL_LOAD_BYTES = 8'h20;
    localparam logic [23:0] LOAD_BASE = 24'h00fa40;
    localparam logic [15:0] XPER_SELECT = 16'h042d;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int RAM_AW = 7;
    localparam int RAM_WORDS = 128;
    typedef enum logic [5:0] {
        ST_WAIT = 6'h01,
        ST_MEASURE = 6'h02,
        ST_DIV_PRE = 6'h04,
        ST_DIV_TQ = 6'h08,
        ST_LOAD = 6'h10,
        ST_DONE = 6'h20
    } cba_state_t;
endpackage

// [cba_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module cba_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic in_valid, // Write side offers a word.
    output logic in_ready, // Space available.
    input wire logic [WIDTH-1:0] in_data, // Word written.
    output logic out_valid, // A word is stored.
    input wire logic out_ready, // Read side takes the word.
    output logic [WIDTH-1:0] out_data // Oldest stored word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] fill_ff;
    logic push;
    logic pop;

    assign in_ready = (fill_ff != (AW+1)'(DEPTH));
    assign out_valid = (fill_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            fill_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                fill_ff <= fill_ff + 1'b1;
            end else if (pop && !push) begin
                fill_ff <= fill_ff - 1'b1;
            end
        end
    end
endmodule // cba_fifo

// [cba_boot_ram.sv]
// Boot load area: one write port, one read port with registered data.
`timescale 1ns/1ps
module cba_boot_ram (
    input wire logic clk, // System clock.
    input wire logic wr_en, // Write strobe.
    input wire logic [cba_pkg::RAM_AW-1:0] wr_addr, // Write location.
    input wire logic [cba_pkg::BYTE_W-1:0] wr_data, // Byte written.
    input wire logic [cba_pkg::RAM_AW-1:0] rd_addr, // Read location.
    output logic [cba_pkg::BYTE_W-1:0] rd_data // Byte read, one cycle late.
);
    logic [cba_pkg::BYTE_W-1:0] mem_ff [cba_pkg::RAM_WORDS];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data <= mem_ff[rd_addr];
    end
endmodule // cba_boot_ram

// [cba_autobaud.sv]
// Boot-time CAN bit-rate detection, message setup and start-up code loading.
`timescale 1ns/1ps
module cba_autobaud #(
    parameter logic [7:0] ACK_BYTE = 8'h5a, // Arbitrary value.
    parameter logic [15:0] CHIP_ID = 16'h1234 // Arbitrary value.
) (
    input wire logic clk, // System clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic boot_loader_mode, // Boot strap level, caught after reset.
    input wire logic serial_receive_line, // Serial receive line.
    input wire logic can_receive_line, // CAN receive line, low is dominant.
    output logic can_transmit_line, // CAN transmit pin level.
    output logic can_transmit_oe_n, // Low while the pin is driven.
    output logic transmit_port_bit, // Port latch of the transmit pin.
    output logic can_enable, // CAN interface takes part in the bus.
    output logic timing_valid, // Bit timing fields are valid.
    output logic [cba_pkg::MEASURE_W-1:0] measure_count, // Final count.
    output logic [5:0] prescaler_field, // Prescaler field value.
    output logic [4:0] segment_one_field, // Segment one, quanta minus one.
    output logic [2:0] segment_two_field, // Segment two, quanta minus one.
    output logic [1:0] sjw_field, // Jump width, quanta minus one.
    input wire logic rx_valid, // Received message offered.
    output logic rx_ready, // Received message taken.
    input wire logic [10:0] rx_id, // Received standard identifier.
    input wire logic rx_remote, // Received message is a remote frame.
    input wire logic [7:0] rx_data, // First received data byte.
    output logic [10:0] ack_id, // Acknowledge object identifier.
    output logic [3:0] ack_len, // Acknowledge object length.
    output logic [7:0] ack_data0, // Generic acknowledge byte.
    output logic [7:0] ack_data1, // Chip identifier low byte.
    output logic [7:0] ack_data2, // Chip identifier high byte.
    output logic ack_tx_request, // One-cycle request to send acknowledge.
    output logic [10:0] recv_id, // Receive object identifier.
    output logic [10:0] recv_mask, // Receive object acceptance mask.
    output logic [15:0] peripheral_select, // Enabled extended peripherals.
    input wire logic store_stall, // Holds the load stores off.
    output logic [7:0] load_count, // Bytes stored so far.
    output logic jump_valid, // Load complete, start execution.
    output logic [23:0] jump_address, // Execution start address.
    input wire logic [cba_pkg::RAM_AW-1:0] ram_read_addr, // Load area read.
    output logic [cba_pkg::BYTE_W-1:0] ram_read_data // Load area data.
);
    cba_pkg::cba_state_t state_ff;
    cba_pkg::cba_state_t nxt_state;
    logic strap_taken_ff;
    logic boot_ff;
    logic can_prev_ff;
    logic [3:0] stuff_ff;
    logic [cba_pkg::MEASURE_W-1:0] count_ff;
    logic [cba_pkg::MEASURE_W-1:0] rem_ff;
    logic [11:0] divisor_ff;
    logic [5:0] quanta_ff;
    logic [5:0] pre_ff;
    logic ack_done_ff;
    logic [7:0] load_ff;
    logic start_low;
    logic can_rise;
    logic fifth_stuff;
    logic overflow;
    logic pre_step;
    logic tq_step;
    logic [5:0] quanta_round;
    logic rx_take;
    logic rx_is_load;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;

    // Segment split keeps sample point inside 70 to 80 percent.
    function automatic logic [2:0] seg_two_of(input logic [5:0] q);
        logic [5:0] t;
        t = (q + 6'h01) >> 2;
        return t[2:0];
    endfunction

    function automatic logic [5:0] clamp_quanta(input logic [5:0] q);
        if (q < cba_pkg::TQ_MIN) begin
            return cba_pkg::TQ_MIN;
        end else if (q > cba_pkg::TQ_MAX) begin
            return cba_pkg::TQ_MAX;
        end
        return q;
    endfunction

    // The strap is caught on the first edge after reset release.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_taken_ff <= 1'b0;
            boot_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            boot_ff <= boot_loader_mode;
        end
    end

    assign start_low = boot_ff && (!serial_receive_line || !can_receive_line);
    // One register stage on the line bounds the edge error to one cycle.
    assign can_rise = can_receive_line && !can_prev_ff;
    assign fifth_stuff = can_rise && (stuff_ff == cba_pkg::STUFF_TARGET - 4'h1);
    assign overflow = (count_ff == {cba_pkg::MEASURE_W{1'b1}});
    assign pre_step = (rem_ff >= cba_pkg::PRESCALE_SPAN);
    assign tq_step = (rem_ff >= 16'(divisor_ff));
    assign quanta_round = ({rem_ff[14:0], 1'b0} > 16'(divisor_ff)) ? quanta_ff + 6'h01 : quanta_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cba_pkg::ST_WAIT: begin
                if (start_low) begin
                    nxt_state = cba_pkg::ST_MEASURE;
                end
            end
            cba_pkg::ST_MEASURE: begin
                if (fifth_stuff) begin
                    nxt_state = cba_pkg::ST_DIV_PRE;
                end else if (overflow) begin
                    nxt_state = cba_pkg::ST_WAIT;
                end
            end
            cba_pkg::ST_DIV_PRE: begin
                if (!pre_step) begin
                    nxt_state = cba_pkg::ST_DIV_TQ;
                end
            end
            cba_pkg::ST_DIV_TQ: begin
                if (!tq_step) begin
                    nxt_state = cba_pkg::ST_LOAD;
                end
            end
            cba_pkg::ST_LOAD: begin
                if (load_ff == cba_pkg::CAN_LOAD_BYTES) begin
                    nxt_state = cba_pkg::ST_DONE;
                end
            end
            cba_pkg::ST_DONE: begin
                nxt_state = cba_pkg::ST_DONE;
            end
            default: begin
                nxt_state = cba_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= cba_pkg::ST_WAIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Measurement of the zero frame.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            can_prev_ff <= 1'b1;
            stuff_ff <= 4'h0;
            count_ff <= '0;
        end else begin
            can_prev_ff <= can_receive_line;
            if (state_ff == cba_pkg::ST_WAIT) begin
                stuff_ff <= 4'h0;
                count_ff <= start_low ? 16'h0001 : 16'h0000;
            end else if (state_ff == cba_pkg::ST_MEASURE && !fifth_stuff) begin
                count_ff <= count_ff + 16'h0001;
                if (can_rise) begin
                    stuff_ff <= stuff_ff + 4'h1;
                end
            end
        end
    end

    // Two repeated-subtraction divisions; the second divides by 58 times the prescaler field plus one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem_ff <= '0;
            pre_ff <= 6'h00;
            divisor_ff <= cba_pkg::TQ_UNIT;
            quanta_ff <= 6'h00;
        end else begin
            case (state_ff)
                cba_pkg::ST_MEASURE: begin
                    rem_ff <= count_ff;
                    pre_ff <= 6'h00;
                    divisor_ff <= cba_pkg::TQ_UNIT;
                    if (fifth_stuff) begin
                        rem_ff <= count_ff;
                    end
                end
                cba_pkg::ST_DIV_PRE: begin
                    if (pre_step) begin
                        rem_ff <= rem_ff - cba_pkg::PRESCALE_SPAN;
                        pre_ff <= pre_ff + 6'h01;
                        divisor_ff <= divisor_ff + cba_pkg::TQ_UNIT;
                    end else begin
                        rem_ff <= count_ff;
                        quanta_ff <= 6'h00;
                    end
                end
                cba_pkg::ST_DIV_TQ: begin
                    if (tq_step) begin
                        rem_ff <= rem_ff - 16'(divisor_ff);
                        quanta_ff <= quanta_ff + 6'h01;
                    end
                end
                default: begin
                    rem_ff <= rem_ff;
                end
            endcase
        end
    end

    // Bit timing outputs, loaded once when the quotient settles.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timing_valid <= 1'b0;
            measure_count <= '0;
            prescaler_field <= 6'h00;
            segment_one_field <= 5'h00;
            segment_two_field <= 3'h0;
            sjw_field <= 2'h0;
        end else if (state_ff == cba_pkg::ST_DIV_TQ && !tq_step) begin
            timing_valid <= 1'b1;
            measure_count <= count_ff;
            prescaler_field <= pre_ff;
            // Quanta are clamped to the legal range before the split.
            segment_two_field <= seg_two_of(clamp_quanta(quanta_round)) - 3'h1;
            segment_one_field <= 5'(clamp_quanta(quanta_round)
                - 6'(seg_two_of(clamp_quanta(quanta_round))) - 6'h02);
            sjw_field <= cba_pkg::SJW_FIELD;
        end
    end

    // Pin and object setup once the bit rate is known.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            can_enable <= 1'b0;
            transmit_port_bit <= 1'b0;
            can_transmit_oe_n <= 1'b1;
            ack_id <= 11'h000;
            ack_len <= 4'h0;
            ack_data0 <= 8'h00;
            ack_data1 <= 8'h00;
            ack_data2 <= 8'h00;
            recv_id <= 11'h000;
            recv_mask <= 11'h000;
        end else if (state_ff == cba_pkg::ST_DIV_TQ && !tq_step) begin
            can_enable <= 1'b1;
            transmit_port_bit <= 1'b1;
            can_transmit_oe_n <= 1'b0;
            ack_id <= cba_pkg::ACK_ID;
            ack_len <= cba_pkg::ACK_LEN;
            ack_data0 <= ACK_BYTE;
            ack_data1 <= CHIP_ID[7:0];
            ack_data2 <= CHIP_ID[15:8];
            recv_id <= cba_pkg::RECV_ID;
            recv_mask <= cba_pkg::RECV_MASK;
        end
    end

    // Transmit pin stays recessive; the CAN engine owns actual frames.
    assign can_transmit_line = 1'b1;
    // The selection is a constant so the host cannot change it here.
    assign peripheral_select = cba_pkg::XPER_SELECT;

    // Only the first remote frame for the acknowledge is answered.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_done_ff <= 1'b0;
            ack_tx_request <= 1'b0;
        end else begin
            ack_tx_request <= 1'b0;
            if (rx_take && rx_remote && rx_id == cba_pkg::ACK_ID && !ack_done_ff) begin
                ack_tx_request <= 1'b1;
                ack_done_ff <= 1'b1;
            end
        end
    end

    // Data frames for the receive object feed the FIFO in ST_LOAD; in ST_DONE they are taken and dropped; length is ignored.
    assign rx_is_load = !rx_remote && ((rx_id & cba_pkg::RECV_MASK) == cba_pkg::RECV_ID);
    assign rx_ready = (state_ff == cba_pkg::ST_LOAD || state_ff == cba_pkg::ST_DONE)
        && (!rx_is_load || fifo_in_ready);
    assign rx_take = rx_valid && rx_ready;

    cba_fifo #(
        .WIDTH(cba_pkg::BYTE_W),
        .DEPTH(cba_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(rx_valid && rx_is_load && state_ff == cba_pkg::ST_LOAD),
        .in_ready(fifo_in_ready),
        .in_data(rx_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Stores stop at the byte limit so the area cannot wrap.
    assign fifo_out_ready = !store_stall && (load_ff < cba_pkg::CAN_LOAD_BYTES);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_ff <= 8'h00;
            jump_valid <= 1'b0;
            jump_address <= 24'h000000;
        end else begin
            if (fifo_out_valid && fifo_out_ready) begin
                load_ff <= load_ff + 8'h01;
            end
            if (state_ff == cba_pkg::ST_LOAD && load_ff == cba_pkg::CAN_LOAD_BYTES) begin
                jump_valid <= 1'b1;
                jump_address <= cba_pkg::LOAD_BASE;
            end
        end
    end

    assign load_count = load_ff;

    cba_boot_ram u_ram (
        .clk(clk),
        .wr_en(fifo_out_valid && fifo_out_ready),
        .wr_addr(load_ff[cba_pkg::RAM_AW-1:0]),
        .wr_data(fifo_out_data),
        .rd_addr(ram_read_addr),
        .rd_data(ram_read_data)
    );
endmodule // cba_autobaud

// [cba_autobaud_sva.sv]
// Port-level assertions for the CAN boot bit-rate detector.
`timescale 1ns/1ps
module cba_autobaud_sva (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic rx_valid, // Message offered.
    input wire logic rx_ready, // Message taken.
    input wire logic [10:0] rx_id, // Offered identifier.
    input wire logic rx_remote, // Offered remote frame.
    input wire logic can_transmit_line, // Pin level.
    input wire logic can_transmit_oe_n, // Pin enable, low drives.
    input wire logic transmit_port_bit, // Port latch.
    input wire logic timing_valid, // Fields valid.
    input wire logic [4:0] segment_one_field, // Segment one.
    input wire logic [2:0] segment_two_field, // Segment two.
    input wire logic [1:0] sjw_field, // Jump width.
    input wire logic [10:0] ack_id, // Acknowledge identifier.
    input wire logic [3:0] ack_len, // Acknowledge length.
    input wire logic ack_tx_request, // Acknowledge send pulse.
    input wire logic [10:0] recv_id, // Receive identifier.
    input wire logic [10:0] recv_mask, // Receive mask.
    input wire logic [7:0] load_count, // Bytes stored.
    input wire logic jump_valid, // Load complete.
    input wire logic [23:0] jump_address // Start address.
);
    logic [1:0] ack_seen_ff;
    // Saturates at two so that repeated requests cannot wrap back to a legal count.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_seen_ff <= 2'h0;
        end else if (ack_tx_request && ack_seen_ff != 2'h2) begin
            ack_seen_ff <= ack_seen_ff + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_sjw;
        timing_valid |-> sjw_field == cba_pkg::SJW_FIELD;
    endproperty
    a_sjw: assert property (p_sjw) else $error("jump width field wrong");
    property p_pin;
        timing_valid |-> !can_transmit_oe_n && transmit_port_bit && can_transmit_line;
    endproperty
    a_pin: assert property (p_pin) else $error("transmit pin not driven recessive");
    property p_ack;
        timing_valid |-> ack_id == cba_pkg::ACK_ID && ack_len == cba_pkg::ACK_LEN;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge object wrong");
    property p_recv;
        timing_valid |-> recv_id == cba_pkg::RECV_ID && recv_mask == cba_pkg::RECV_MASK;
    endproperty
    a_recv: assert property (p_recv) else $error("receive object wrong");
    property p_req;
        ack_tx_request |-> $past(rx_valid && rx_ready && rx_remote && rx_id == cba_pkg::ACK_ID);
    endproperty
    a_req: assert property (p_req) else $error("acknowledge sent without request");
    property p_once;
        ack_seen_ff != 2'h2;
    endproperty
    a_once: assert property (p_once) else $error("second acknowledge sent");
    property p_quanta;
        timing_valid |-> ({3'h0, segment_one_field} + {5'h0, segment_two_field} + 8'h03)
            inside {[8'h08:8'h19]};
    endproperty
    a_quanta: assert property (p_quanta) else $error("quanta per bit out of range");
    property p_jump;
        $rose(jump_valid) |-> jump_address == cba_pkg::LOAD_BASE
            && load_count == cba_pkg::CAN_LOAD_BYTES;
    endproperty
    a_jump: assert property (p_jump) else $error("jump before load complete");
endmodule // cba_autobaud_sva
bind cba_autobaud cba_autobaud_sva u_sva (.clk, .rst, .rx_valid, .rx_ready, .rx_id, .rx_remote,
    .can_transmit_line, .can_transmit_oe_n, .transmit_port_bit, .timing_valid, .segment_one_field,
    .segment_two_field, .sjw_field, .ack_id, .ack_len, .ack_tx_request, .recv_id, .recv_mask,
    .load_count, .jump_valid, .jump_address);

// [cba_host_model.sv]
// Behavioural CAN host that sends the zero frame and the boot messages.
`timescale 1ns/1ps
module cba_host_model (
    input wire logic clk, // System clock.
    output logic can_receive_line, // Bus level seen by the device.
    output logic rx_valid, // Message offered.
    input wire logic rx_ready, // Message taken.
    output logic [10:0] rx_id, // Identifier.
    output logic rx_remote, // Remote frame flag.
    output logic [7:0] rx_data // Single data byte.
);
    initial begin
        can_receive_line = 1'b1;
        rx_valid = 1'b0;
        rx_id = 11'h7aa;
        rx_remote = 1'b0;
        rx_data = 8'ha5;
    end
    // Dominant and recessive runs of the all-zero frame, stuff bits included.
    task automatic zero_frame(input int bit_cyc);
        int runs[14] = '{5, 1, 5, 1, 5, 1, 5, 1, 5, 1, 4, 1, 1, 11};
        for (int i = 0; i < 14; i++) begin
            can_receive_line <= i[0];
            repeat (runs[i] * bit_cyc) @(posedge clk);
        end
    endtask
    // Request held until taken; afterwards identifier and data are inverted so stale data never matches.
    task automatic send_msg(input logic [10:0] id, input logic remote, input logic [7:0] data);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_remote <= remote;
        rx_data <= data;
        do @(negedge clk); while (rx_ready !== 1'b1);
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_data <= ~data;
    endtask
endmodule // cba_host_model

// [tb_top.sv]
// Self-checking bench for the CAN boot bit-rate detector.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic boot_loader_mode = 1'b1;
    logic serial_receive_line = 1'b1;
    logic store_stall = 1'b0;
    logic [cba_pkg::RAM_AW-1:0] ram_read_addr = 7'h00;
    logic can_receive_line, rx_valid, rx_ready, rx_remote, ack_tx_request, jump_valid;
    logic can_transmit_line, can_transmit_oe_n, transmit_port_bit, can_enable, timing_valid;
    logic [10:0] rx_id, ack_id, recv_id, recv_mask;
    logic [7:0] rx_data, ack_data0, ack_data1, ack_data2, load_count, ram_read_data;
    logic [15:0] measure_count, peripheral_select;
    logic [5:0] prescaler_field;
    logic [4:0] segment_one_field;
    logic [2:0] segment_two_field;
    logic [1:0] sjw_field;
    logic [3:0] ack_len;
    logic [23:0] jump_address;
    int fails = 0;
    int samples_checked = 0;
    int ack_pulses = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (ack_tx_request === 1'b1) ack_pulses++;
    cba_host_model host (.clk, .can_receive_line, .rx_valid, .rx_ready, .rx_id, .rx_remote,
        .rx_data);
    cba_autobaud #(.ACK_BYTE(8'h3c), .CHIP_ID(16'h4a71)) dut (.clk, .rst, .boot_loader_mode,
        .serial_receive_line, .can_receive_line, .can_transmit_line, .can_transmit_oe_n,
        .transmit_port_bit, .can_enable, .timing_valid, .measure_count, .prescaler_field,
        .segment_one_field, .segment_two_field, .sjw_field, .rx_valid, .rx_ready, .rx_id,
        .rx_remote, .rx_data, .ack_id, .ack_len, .ack_data0, .ack_data1, .ack_data2,
        .ack_tx_request, .recv_id, .recv_mask, .peripheral_select, .store_stall, .load_count,
        .jump_valid, .jump_address, .ram_read_addr, .ram_read_data);
    // The pattern is plain data, so no executable code lands in the upper load area.
    function automatic logic [7:0] byte_at(input int i);
        return 8'(i * 37 + 11);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset(input logic mode);
        @(posedge clk);
        rst <= 1'b1;
        boot_loader_mode <= mode;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset_state();
        repeat (2) @(negedge clk);
        chk({30'h0, can_transmit_oe_n, can_transmit_line}, 32'h3);
        chk({23'h0, timing_valid, load_count}, 32'h0);
        chk(32'(peripheral_select), 32'(cba_pkg::XPER_SELECT));
    endtask
    task automatic t_strap_low();
        do_reset(1'b0);
        host.zero_frame(20);
        repeat (200) @(negedge clk);
        chk({30'h0, timing_valid, rx_ready}, 32'h0);
    endtask
    task automatic t_measure(input int bit_cyc, input int lead, input logic [5:0] pre,
        input logic [4:0] s1, input logic [2:0] s2);
        int diff;
        do_reset(1'b1);
        if (lead > 0) begin
            serial_receive_line <= 1'b0;
            repeat (lead) @(posedge clk);
        end
        host.zero_frame(bit_cyc);
        serial_receive_line <= 1'b1;
        for (int n = 0; n < 500 && timing_valid !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        diff = int'(measure_count) - (29 * bit_cyc + lead);
        chk({31'h0, diff >= -6 && diff <= 6}, 32'h1);
        chk(32'(prescaler_field), 32'(pre));
        chk(32'(segment_one_field), 32'(s1));
        chk(32'(segment_two_field), 32'(s2));
        chk(32'(sjw_field), 32'(cba_pkg::SJW_FIELD));
        chk({29'h0, can_transmit_oe_n, transmit_port_bit, can_enable}, 32'h3);
    endtask
    task automatic t_objects();
        chk({17'h0, ack_len, ack_id}, {17'h0, 4'h3, 11'h0e6});
        chk({8'h0, ack_data2, ack_data1, ack_data0}, 32'h004a713c);
        chk({10'h0, recv_id, recv_mask}, {10'h0, 11'h005, 11'h7ff});
        chk(ack_pulses, 0);
        host.send_msg(11'h003, 1'b0, 8'h11);
        host.send_msg(cba_pkg::ACK_ID, 1'b1, 8'h00);
        repeat (3) @(negedge clk);
        chk(ack_pulses, 1);
        host.send_msg(cba_pkg::ACK_ID, 1'b1, 8'h00);
        repeat (3) @(negedge clk);
        chk(ack_pulses, 1);
        chk(32'(load_count), 32'h0);
    endtask
    task automatic t_load();
        @(posedge clk);
        store_stall <= 1'b1;
        for (int i = 0; i < 8; i++) host.send_msg(cba_pkg::RECV_ID, 1'b0, byte_at(i));
        repeat (3) @(negedge clk);
        chk(32'(load_count), 32'h0);
        fork
            begin
                repeat (30) @(posedge clk);
                store_stall <= 1'b0;
            end
        join_none
        host.send_msg(cba_pkg::RECV_ID, 1'b0, byte_at(8));
        chk({31'h0, store_stall}, 32'h0);
        for (int i = 9; i < 128; i++) begin
            if (i == 64) host.send_msg(11'h405, 1'b0, 8'hee);
            host.send_msg(cba_pkg::RECV_ID, 1'b0, byte_at(i));
        end
        for (int n = 0; n < 100 && jump_valid !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        chk(32'(load_count), 32'h80);
        chk({7'h0, jump_valid, jump_address}, {8'h01, cba_pkg::LOAD_BASE});
        host.send_msg(cba_pkg::RECV_ID, 1'b0, 8'hff);
        repeat (3) @(negedge clk);
        chk(32'(load_count), 32'h80);
        chk(ack_pulses, 1);
        for (int a = 0; a < 128; a++) begin
            @(posedge clk);
            ram_read_addr <= 7'(a);
            @(posedge clk);
            @(negedge clk);
            chk(32'(ram_read_data), 32'(byte_at(a)));
        end
    endtask
    initial begin
        t_reset_state();
        t_strap_low();
        t_measure(60, 0, 6'h01, 5'h09, 3'h3);
        t_measure(20, 40, 6'h00, 5'h06, 3'h2);
        t_measure(20, 0, 6'h00, 5'h06, 3'h1);
        t_objects();
        t_load();
        wrap_up();
    end
    initial begin
        #500000;
        fails++;
        wrap_up();
    end
endmodule // tb_top
